// *** hw/phy_mii_port.sv ***
// One 10/100 port seen from the MAC: MII data path, carrier and collision,
// loopback, packet self-test, LED polarity and the management registers.
// Assumes mii_clk is the 2.5/25 MHz port clock and clk the 250 MHz core clock.
`timescale 1ns/10ps
module phy_mii_port #(
  parameter logic [4:0] PHYAD = `PHYAD_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  mii_clk,
  // Management pins, sampled in the core domain
  input  wire logic                  mdc,
  input  wire logic                  mdio_i,
  output logic                       mdio_o,
  output logic                       mdio_oe,
  // MAC side
  output logic                       tx_clk,
  output logic                       rx_clk,
  input  wire logic [3:0]            txd,
  input  wire logic                  tx_en,
  output phy_port_pkg::mii_rx_t      mii_rx,
  // Media side, on mii_clk
  output logic [3:0]                 media_txd,
  output logic                       media_tx_en,
  input  wire logic [3:0]            media_rxd,
  input  wire logic                  media_rx_dv,
  input  wire logic                  media_rx_er,
  input  wire logic                  squelch_ok,
  input  wire logic                  signal_detect,
  input  wire logic                  line_bit,
  // Negotiation results, core domain
  input  wire logic                  link_up,
  input  wire logic                  an_full,
  input  wire logic                  an_speed100,
  input  wire logic                  link_by_pardet,
  // LEDs
  input  wire logic [2:0]            autoneg_strap_input,
  input  wire logic [2:0]            led_func,
  output logic [2:0]                 led
);
  import phy_port_pkg::*;

  core_st_t cq, cd;
  link_st_t lq, ld;
  logic [2:0] lrst;
  logic       lrstn;
  logic       eff_full, eff_s100, rise, bitv;
  cfg_t       cfg_src;
  logic [15:0] rd_data, wr_word;
  logic [7:0]  err_bin;

  // Clocks to the MAC are the port clock itself; MII is the only mode built here
  assign tx_clk = mii_clk;
  assign rx_clk = mii_clk;

  //////////////////////////////////////////////////////////////////////////////
  // Nibble step of the pseudo-random generator; returns {nibble, state}
  function automatic logic [18:0] lfsr4(input logic [14:0] s, input logic l15);
    logic [14:0] v;
    logic [3:0]  n;
    logic        fb;
    v = s;
    n = 4'h0;
    for (int i = 0; i < 4; i++) begin
      fb = l15 ? (v[14] ^ v[13]) : (v[8] ^ v[4]);
      v  = {v[13:0], fb};
      n  = {n[2:0], fb};
    end
    return {n, v};
  endfunction : lfsr4

  //////////////////////////////////////////////////////////////////////////////
  // Link-domain reset follows the core reset through a short chain
  always_ff @(posedge mii_clk) begin
    lrst <= {lrst[1:0], rstn};
  end
  assign lrstn = lrst[2];

  // Duplex and speed actually in force
  always_comb begin
    if (cq.basic_control_register[`BASIC_CONTROL_REGISTER_ANEN]) begin
      eff_full = link_by_pardet ? 1'b0 : an_full;
      eff_s100 = an_speed100;
    end else begin
      eff_full = cq.basic_control_register[`BASIC_CONTROL_REGISTER_DUPLEX];
      eff_s100 = cq.basic_control_register[`BASIC_CONTROL_REGISTER_SPEED];
    end
    cfg_src = '{loop: cq.basic_control_register[`BASIC_CONTROL_REGISTER_LOOP], full: eff_full, s100: eff_s100,
                bist_run: cq.phy_control_register[`PHY_CONTROL_REGISTER_BIST_RUN], psr15: cq.phy_control_register[`PHY_CONTROL_REGISTER_PSR15],
                cont: cq.cont, hb: cq.phy_control_register[`PHY_CONTROL_REGISTER_HB], restart: cq.restart};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: self-test, loopback, carrier, collision
  always_comb begin
    logic [18:0] tx_step, rx_step;
    logic [3:0]  e_txd;
    logic        e_txen, bist_on, src_dv, col_st, rx_sel_dv;
    e_txd     = 4'h0;
    e_txen    = 1'b0;
    bist_on   = 1'b0;
    src_dv    = 1'b0;
    col_st    = 1'b0;
    rx_sel_dv = 1'b0;
    ld = lq;
    tx_step = lfsr4(lq.tx_lfsr, lq.cfg.psr15);
    rx_step = lfsr4(lq.rx_lfsr, lq.cfg.psr15);
    // Settings: taken once stages two and three agree
    ld.c1 = cfg_src;
    ld.c2 = lq.c1;
    ld.c3 = lq.c2;
    for (int i = 0; i < 8; i++) begin
      if (lq.c2[i] == lq.c3[i]) ld.cfg[i] = lq.c3[i];
    end
    bist_on = lq.cfg.bist_run;
    // Self-test transmitter
    e_txd  = txd;
    e_txen = tx_en;
    if (bist_on) begin
      e_txen = lq.cfg.cont | ~lq.bist_gap;
      e_txd  = tx_step[18:15];
      if (e_txen) ld.tx_lfsr = tx_step[14:0];
      if (!lq.cfg.cont) begin
        ld.bist_cnt = lq.bist_cnt + 8'h01;
        if (!lq.bist_gap && lq.bist_cnt == `BIST_PKT_NIB) begin
          ld.bist_gap = 1'b1;
          ld.bist_cnt = 8'h00;
        end else if (lq.bist_gap && lq.bist_cnt == `BIST_GAP_NIB) begin
          ld.bist_gap = 1'b0;
          ld.bist_cnt = 8'h00;
        end
      end
    end
    // Media transmit, silent in loopback
    ld.m_txd   = e_txd;
    ld.m_tx_en = e_txen & ~lq.cfg.loop;
    // Receive source
    rx_sel_dv   = lq.cfg.loop ? e_txen : media_rx_dv;
    ld.rx.rx_dv = rx_sel_dv;
    ld.rx.rxd   = lq.cfg.loop ? e_txd : media_rxd;
    ld.rx.rx_er = lq.cfg.loop ? 1'b0 : media_rx_er;
    // Self-test receiver
    if (bist_on && rx_sel_dv) begin
      ld.rx_lfsr = rx_step[14:0];
      if (ld.rx.rxd == rx_step[18:15]) begin
        if (!lq.fail) ld.pass = 1'b1;
      end else begin
        ld.fail = 1'b1;
        ld.pass = 1'b0;
        if (lq.err != 8'hff) ld.err = lq.err + 8'h01;
      end
    end
    // Restart clears the latched result and reseeds both generators
    if (lq.cfg.restart != lq.c3.restart && lq.c2.restart == lq.c3.restart) begin
      ld.fail     = 1'b0;
      ld.pass     = 1'b0;
      ld.err      = 8'h00;
      ld.tx_lfsr  = `LFSR_SEED;
      ld.rx_lfsr  = `LFSR_SEED;
      ld.bist_cnt = 8'h00;
      ld.bist_gap = 1'b0;
    end
    ld.err_gray = ld.err ^ {1'b0, ld.err[7:1]};
    // Carrier from the line
    src_dv       = media_rx_dv;
    ld.rxdv_prev = src_dv;
    if (!lq.cfg.s100) begin
      ld.car = squelch_ok;
    end else if (!signal_detect) begin
      ld.car  = 1'b0;
      ld.zero = 1'b0;
      ld.gap  = 1'b0;
    end else if (!lq.car) begin
      if (!line_bit) begin
        if (lq.gap) ld.car = 1'b1;
        else ld.zero = 1'b1;
      end else if (lq.zero) begin
        ld.gap = 1'b1;
      end
    end else if (lq.rxdv_prev && !src_dv) begin
      ld.car  = 1'b0;
      ld.zero = 1'b0;
      ld.gap  = 1'b0;
    end
    // Carrier sense toward the MAC
    if (lq.cfg.loop) ld.rx.crs = rx_sel_dv;
    else ld.rx.crs = lq.car | (e_txen & ~lq.cfg.full);
    // Collision: receive first means report at once
    if (!lq.car) ld.rx_first = 1'b0;
    else if (!lq.rxdv_prev && !e_txen) ld.rx_first = 1'b1;
    col_st = ~lq.cfg.full & ~lq.cfg.loop & e_txen & lq.car;
    if (!col_st) ld.col_cnt = 2'b00;
    else if (lq.col_cnt != 2'b11) ld.col_cnt = lq.col_cnt + 2'b01;
    // Heartbeat after each transmitted packet at 10 Mb/s half duplex
    ld.txen_prev = e_txen;
    if (lq.sqe_cnt != 3'b000) ld.sqe_cnt = lq.sqe_cnt - 3'b001;
    if (lq.txen_prev && !e_txen && lq.cfg.hb && !lq.cfg.s100 && !lq.cfg.full)
      ld.sqe_cnt = 3'(`SQE_GAP_CYC + `SQE_CYC);
    ld.rx.col = (col_st & (lq.rx_first | lq.cfg.s100 |
                 (lq.col_cnt >= 2'(`COL_DLY_CYC - 1))))
              | (lq.sqe_cnt != 3'b000 && lq.sqe_cnt <= 3'(`SQE_CYC));
    if (!lrstn) begin
      ld         = '0;
      ld.tx_lfsr = `LFSR_SEED;
      ld.rx_lfsr = `LFSR_SEED;
    end
  end

  always_ff @(posedge mii_clk) begin
    lq <= ld;
  end

  assign mii_rx      = lq.rx;
  assign media_txd   = lq.m_txd;
  assign media_tx_en = lq.m_tx_en;

  //////////////////////////////////////////////////////////////////////////////
  // Register read view; the LED register returns what was written, not pins
  always_comb begin
    err_bin    = '0;
    err_bin[7] = cq.lstat[7];
    for (int i = 6; i >= 0; i--) begin
      err_bin[i] = err_bin[i + 1] ^ cq.lstat[i];
    end
    unique case (cq.regad)
      `REG_BASIC_CONTROL_REGISTER:    rd_data = cq.basic_control_register;
      `REG_PHY_STATUS_REGISTER:  rd_data = {12'h000, cq.basic_control_register[`BASIC_CONTROL_REGISTER_LOOP], eff_full,
                               ~eff_s100, link_up};
      `REG_LED_DIRECT_CONTROL:   rd_data = cq.led_direct_control;
      `REG_PHY_CONTROL_REGISTER:   rd_data = {cq.phy_control_register[15:10], cq.lstat[8], cq.phy_control_register[8:5], PHYAD};
      `REG_CABLE_DIAG_CONTROL_ONE: rd_data = {err_bin, 2'b00, cq.cont, 5'h00};
      default:      rd_data = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: management frames, registers, LEDs
  always_comb begin
    cd = cq;
    // Pins: three stages, accept when the last two agree
    cd.p1 = {mdio_i, mdc};
    cd.p2 = cq.p1;
    cd.p3 = cq.p2;
    if (cq.p2[0] == cq.p3[0]) cd.mdc_f = cq.p3[0];
    if (cq.p2[1] == cq.p3[1]) cd.mdio_f = cq.p3[1];
    rise    = cd.mdc_f & ~cq.mdc_f;
    bitv    = cd.mdio_f;
    wr_word = {cq.sh[14:0], bitv};
    if (rise) begin
      unique case (cq.st)
        M_PRE: begin
          if (bitv) begin
            if (cq.cnt != 6'(`PRE_ONES)) cd.cnt = cq.cnt + 6'h01;
          end else if (cq.pre_ok || cq.cnt == 6'(`PRE_ONES)) begin
            cd.st  = M_HDR;
            cd.cnt = 6'h00;
          end else begin
            cd.cnt = 6'h00;
          end
        end
        M_HDR: begin
          cd.sh  = wr_word;
          cd.cnt = cq.cnt + 6'h01;
          if (cq.cnt == 6'd12) begin
            cd.cnt = 6'h00;
            if (!wr_word[12] || wr_word[11] == wr_word[10]) begin
              cd.st     = M_PRE; // Bad start or opcode: preamble needed again
              cd.pre_ok = 1'b0;
            end else begin
              cd.st      = M_TA;
              cd.op_rd   = wr_word[11];
              cd.addr_ok = wr_word[9:5] == PHYAD;
              cd.regad   = wr_word[4:0];
            end
          end
        end
        M_TA: begin
          cd.cnt = cq.cnt + 6'h01;
          if (cq.cnt == 6'h00 && cq.op_rd && cq.addr_ok) begin
            cd.oe   = 1'b1;
            cd.dout = 1'b0;
            cd.sh   = rd_data;
          end
          if (cq.cnt == 6'h01) begin
            cd.st   = M_DATA;
            cd.cnt  = 6'h00;
            cd.dout = cq.sh[15];
          end
        end
        M_DATA: begin
          cd.cnt = cq.cnt + 6'h01;
          if (cq.op_rd) begin
            cd.dout = cq.sh[14];
            cd.sh   = {cq.sh[14:0], 1'b0};
          end else begin
            cd.sh = wr_word;
          end
          if (cq.cnt == 6'd15) begin
            cd.st     = M_PRE;
            cd.cnt    = 6'(`PRE_ONES);
            cd.pre_ok = 1'b1;
            cd.oe     = 1'b0;
            if (!cq.op_rd && cq.addr_ok) begin
              unique case (cq.regad)
                `REG_BASIC_CONTROL_REGISTER:    cd.basic_control_register = wr_word;
                `REG_LED_DIRECT_CONTROL:   cd.led_direct_control = wr_word;
                `REG_PHY_CONTROL_REGISTER: begin
                  cd.phy_control_register   = wr_word;
                  cd.restart = ~cq.restart;
                end
                `REG_CABLE_DIAG_CONTROL_ONE: cd.cont = wr_word[`CD_CONT];
                default: ;
              endcase
            end
          end
        end
        default: cd.st = M_PRE;
      endcase
    end
    // Self-test result back from the link domain
    cd.s1 = {lq.pass, lq.err_gray};
    cd.s2 = cq.s1;
    cd.s3 = cq.s2;
    for (int i = 0; i < 9; i++) begin
      if (cq.s2[i] == cq.s3[i]) cd.lstat[i] = cq.s3[i];
    end
    // Strap catch after release, then LED polarity
    cd.t1 = autoneg_strap_input;
    cd.t2 = cq.t1;
    cd.t3 = cq.t2;
    if (cq.strap_cnt != 3'(`STRAP_WAIT)) begin
      cd.strap_cnt = cq.strap_cnt + 3'b001;
      if (cq.t2 == cq.t3) cd.strap = cq.t3;
    end
    for (int i = 0; i < 3; i++) begin
      cd.led[i] = (cq.led_direct_control[`LED_EN_LSB + i] ? cq.led_direct_control[i] : led_func[i])
                ^ cq.strap[i];
    end
    if (!rstn) begin
      cd       = '0;
      cd.st    = M_PRE;
      cd.basic_control_register  = `BASIC_CONTROL_REGISTER_RST;
      cd.phy_control_register = `PHY_CONTROL_REGISTER_RST;
      cd.led_direct_control = `LED_DIRECT_CONTROL_RST;
      cd.p1    = 2'b11;
      cd.p2    = 2'b11;
      cd.p3    = 2'b11;
      // Filtered pins start high, so a high idle clock never looks like a rise
      cd.mdc_f  = 1'b1;
      cd.mdio_f = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    cq <= cd;
  end

  assign mdio_o  = cq.dout;
  assign mdio_oe = cq.oe;
  assign led     = cq.led;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_full_no_col;
    @(posedge mii_clk) disable iff (!lrstn) lq.cfg.full && lq.sqe_cnt == 3'b000
      |=> !lq.rx.col || $past(lq.sqe_cnt) != 3'b000;
  endproperty
  a_full_no_col: assert property (p_full_no_col) else $error("col in full duplex");
  property p_full_crs;
    @(posedge mii_clk) disable iff (!lrstn) lq.cfg.full && !lq.cfg.loop
      |=> lq.rx.crs == $past(lq.car);
  endproperty
  a_full_crs: assert property (p_full_crs) else $error("crs not rx only");
  property p_loop_silent;
    @(posedge mii_clk) disable iff (!lrstn) lq.cfg.loop |=> !lq.m_tx_en;
  endproperty
  a_loop_silent: assert property (p_loop_silent) else $error("media tx in loop");
  property p_loop_data;
    @(posedge mii_clk) disable iff (!lrstn) lq.cfg.loop && !lq.cfg.bist_run && tx_en
      |=> lq.rx.rx_dv && lq.rx.rxd == $past(txd);
  endproperty
  a_loop_data: assert property (p_loop_data) else $error("loop data lost");
  property p_fail_latch;
    @(posedge mii_clk) disable iff (!lrstn) lq.fail && lq.cfg.restart == lq.c3.restart
      |=> lq.fail && !lq.pass;
  endproperty
  a_fail_latch: assert property (p_fail_latch) else $error("fail not latched");
  property p_err_sat;
    @(posedge mii_clk) disable iff (!lrstn) lq.err == 8'hff |=> lq.err inside {8'hff, 8'h00};
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("error count wrapped");
  property p_col_delay;
    @(posedge mii_clk) disable iff (!lrstn) !lq.cfg.s100 && !lq.rx_first
      && lq.col_cnt == 2'b00 && lq.sqe_cnt == 3'b000 |=> !lq.rx.col;
  endproperty
  a_col_delay: assert property (p_col_delay) else $error("early 10M collision");
  property p_sqe_len;
    @(posedge mii_clk) disable iff (!lrstn) $fell(lq.txen_prev) && lq.sqe_cnt == 3'd5
      |-> ##3 lq.rx.col [*3];
  endproperty
  a_sqe_len: assert property (p_sqe_len) else $error("heartbeat length");
  property p_pardet_half;
    @(posedge clk) disable iff (!rstn) cq.basic_control_register[`BASIC_CONTROL_REGISTER_ANEN] && link_by_pardet |-> !eff_full;
  endproperty
  a_pardet_half: assert property (p_pardet_half) else $error("pardet full duplex");
  property p_led_pol;
    @(posedge clk) disable iff (!rstn) cq.led_direct_control[`LED_EN_LSB] |=> cq.led[0] == ($past(cq.led_direct_control[0])
      ^ $past(cq.strap[0]));
  endproperty
  a_led_pol: assert property (p_led_pol) else $error("led polarity");
endmodule : phy_mii_port

// *** hw/phy_port_cfg.svh ***
// Constants of one MII port of a 10/100 transceiver: register map, fields,
// reset values and timing counts.
// Assumes the includer wraps it in a package or module scope.
`ifndef PHY_PORT_CFG_SVH
`define PHY_PORT_CFG_SVH

// Register offsets on the management interface
`define REG_BASIC_CONTROL_REGISTER        5'h00
`define REG_PHY_STATUS_REGISTER      5'h10
`define REG_LED_DIRECT_CONTROL       5'h18
`define REG_PHY_CONTROL_REGISTER       5'h19
`define REG_CABLE_DIAG_CONTROL_ONE     5'h1b
// Field positions
`define BASIC_CONTROL_REGISTER_LOOP       14
`define BASIC_CONTROL_REGISTER_SPEED      13
`define BASIC_CONTROL_REGISTER_ANEN       12
`define BASIC_CONTROL_REGISTER_DUPLEX     8
`define STS_LINK        0
`define STS_SPEED10     1
`define STS_DUPLEX      2
`define STS_LOOP        3
`define PHY_CONTROL_REGISTER_HB        12
`define PHY_CONTROL_REGISTER_PSR15     11
`define PHY_CONTROL_REGISTER_BIST_STS  9
`define PHY_CONTROL_REGISTER_BIST_RUN  8
`define CD_CONT         5
`define CD_ERR_LSB      8
`define LED_EN_LSB      3
// Reset values
`define BASIC_CONTROL_REGISTER_RST        16'h3100
`define PHY_CONTROL_REGISTER_RST       16'h0000
`define LED_DIRECT_CONTROL_RST       16'h0000
`define CABLE_DIAG_CONTROL_ONE_RST     16'h0000
`define PHYAD_DEF       5'h01
// Timing, in link clocks at 10 Mb/s (one nibble = four bit times, 400 ns)
`define NIB_BITS        4
`define NIB_NS          400
`define COL_DLY_BITS    7
`define COL_DLY_CYC     ((`COL_DLY_BITS + `NIB_BITS - 1) / `NIB_BITS)
`define SQE_GAP_NS      1000
`define SQE_GAP_CYC     (`SQE_GAP_NS / `NIB_NS)
`define SQE_BITS        10
`define SQE_CYC         ((`SQE_BITS + `NIB_BITS - 1) / `NIB_BITS)
`define PRE_ONES        32
`define STRAP_WAIT      4
`define BIST_PKT_NIB    8'hff
`define BIST_GAP_NIB    8'h18
`define LFSR_SEED       15'h7fff

`endif

// *** hw/phy_port_pkg.sv ***
// Types shared by the MII port logic.
// Assumes phy_port_cfg.svh is on the include path.
package phy_port_pkg;
  `include "phy_port_cfg.svh"

  // Management frame states
  typedef enum logic [3:0] {
    M_PRE  = 4'b0001,
    M_HDR  = 4'b0010,
    M_TA   = 4'b0100,
    M_DATA = 4'b1000
  } mgmt_state_t;

  // Settings carried into the link domain
  typedef struct packed {
    logic loop;
    logic full;
    logic s100;
    logic bist_run;
    logic psr15;
    logic cont;
    logic hb;
    logic restart;
  } cfg_t;

  // MII pins toward the MAC
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
  } mii_rx_t;

  // Link-side state
  typedef struct packed {
    cfg_t        c1, c2, c3, cfg;
    logic [14:0] tx_lfsr, rx_lfsr;
    logic [7:0]  bist_cnt;
    logic        bist_gap;
    logic        pass, fail;
    logic [7:0]  err, err_gray;
    logic        car, zero, gap, rx_first, rxdv_prev, txen_prev;
    logic [1:0]  col_cnt;
    logic [2:0]  sqe_cnt;
    mii_rx_t     rx;
    logic [3:0]  m_txd;
    logic        m_tx_en;
  } link_st_t;

  // Core-side state
  typedef struct packed {
    logic [1:0]  p1, p2, p3;
    logic        mdc_f, mdio_f;
    mgmt_state_t st;
    logic [5:0]  cnt;
    logic        pre_ok, op_rd, addr_ok;
    logic [4:0]  regad;
    logic [15:0] sh;
    logic        oe, dout;
    logic [15:0] basic_control_register, phy_control_register, led_direct_control;
    logic        cont, restart;
    logic [8:0]  s1, s2, s3, lstat;
    logic [2:0]  t1, t2, t3, strap;
    logic [2:0]  strap_cnt;
    logic [2:0]  led;
  } core_st_t;
endpackage : phy_port_pkg

// *** tb/mac_model.sv ***
// MAC stand-in on the MII transmit side of the port.
// Assumes tx_clk comes from the port; data changes just after its falling edge.
`timescale 1ns/10ps
module mac_model (
  input  wire logic       tx_clk,
  output logic [3:0]      txd,
  output logic            tx_en
);
  initial begin
    txd   = 4'h0;
    tx_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One nibble per transmit clock; idle data inverted so stale data never passes
  task automatic send(input logic [3:0] nib, input int n);
    repeat (n) begin
      @(negedge tx_clk);
      txd   <= nib;
      tx_en <= 1'b1;
    end
    @(negedge tx_clk);
    tx_en <= 1'b0;
    txd   <= ~nib;
  endtask : send
endmodule : mac_model

// *** tb/testbench.sv ***
// Self-checking bench for one MII port: registers, loopback, duplex, self-test.
// Assumes phy_port_pkg is compiled first; management pin has a pull-up.
`timescale 1ns/10ps
module testbench;
  import phy_port_pkg::*;

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

  logic clk = 0, rstn = 0, mii_clk = 0, mdc = 0, tb_oe = 1, tb_bit = 1;
  logic mdio_o, mdio_oe, tx_clk, rx_clk, tx_en, media_tx_en;
  logic [3:0] txd, media_txd, media_rxd = 4'h0;
  logic media_rx_dv = 0, media_rx_er = 0, squelch_ok = 0, signal_detect = 0;
  logic line_bit = 1, link_up = 1, an_full = 1, an_speed100 = 1, link_by_pardet = 1;
  logic [2:0] strap = 3'b010, led_func = 3'b000, led;
  mii_rx_t mii_rx;
  logic [15:0] v;
  int n_fail = 0, check_count = 0;
  wire mdio_i = mdio_oe ? mdio_o : (tb_oe ? tb_bit : 1'b1);

  // Core clock; link clock offset so the two phases stay unrelated
  always #2 clk = ~clk;
  initial begin
    #1.7;
    forever #80 mii_clk = ~mii_clk;
  end

  phy_mii_port DUT (.clk(clk), .rstn(rstn), .mii_clk(mii_clk), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .txd(txd), .tx_en(tx_en), .mii_rx(mii_rx),
    .media_txd(media_txd), .media_tx_en(media_tx_en), .media_rxd(media_rxd),
    .media_rx_dv(media_rx_dv), .media_rx_er(media_rx_er), .squelch_ok(squelch_ok),
    .signal_detect(signal_detect), .line_bit(line_bit), .link_up(link_up),
    .an_full(an_full), .an_speed100(an_speed100), .link_by_pardet(link_by_pardet),
    .autoneg_strap_input(strap), .led_func(led_func), .led(led));

  mac_model mac (.tx_clk(tx_clk), .txd(txd), .tx_en(tx_en));

  ////////////////////////////////////////////////////////////////////////////
  // Management bit: sample line late in low phase, then raise the clock
  task automatic mbit(input logic b, input logic drive);
    tb_oe  = drive;
    tb_bit = b;
    repeat (6) @(negedge clk);
    v   = {v[14:0], mdio_i};
    mdc = 1'b1;
    repeat (6) @(negedge clk);
    mdc = 1'b0;
  endtask : mbit

  // Whole frame; the last sixteen samples are the read data
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] f;
    f = {2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
    for (int i = 31; i >= 0; i--) mbit(f[i], !(rd && i < 18));
    tb_oe = 1'b1;
    repeat (12) @(negedge clk);
  endtask : frame

  task automatic mii_wait(input int n);
    repeat (n * 40) @(negedge clk);
  endtask : mii_wait

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, direct LED drive with strap polarity, unmapped place
  task automatic t_regs;
    frame(1, 5'h00, 16'h0);
    `CHK(v, 16'h3100)
    frame(1, 5'h10, 16'h0);
    `CHK(v[2], 1'b0)
    frame(1, 5'h19, 16'h0);
    `CHK(v, 16'h0001)
    frame(0, 5'h18, 16'h003d);
    frame(1, 5'h18, 16'h0);
    `CHK(v, 16'h003d)
    repeat (10) @(negedge clk);
    `CHK(led, 3'b111)
    frame(1, 5'h1e, 16'h0);
    `CHK(v, 16'h0000)
  endtask : t_regs

  // Loopback at 100 half: nibble returns, media stays quiet
  task automatic t_loop;
    int k;
    frame(0, 5'h00, 16'h6000);
    mii_wait(6);
    frame(1, 5'h10, 16'h0);
    `CHK(v[3], 1'b1)
    fork
      mac.send(4'h5, 4);
      begin
        k = 0;
        while (mii_rx.rx_dv !== 1'b1 && k < 400) begin
          @(negedge clk);
          k++;
        end
        `CHK(mii_rx.rxd, 4'h5)
        `CHK(media_tx_en, 1'b0)
        `CHK(mii_rx.crs, 1'b1)
      end
    join
  endtask : t_loop

  // Overlap of transmit and receive in full, then half duplex
  task automatic t_dup(input logic [15:0] mode, input logic exp_col);
    frame(0, 5'h00, mode);
    mii_wait(6);
    fork
      mac.send(4'h3, 8);
      begin
        mii_wait(5);
        `CHK(mii_rx.col, exp_col)
        `CHK(mii_rx.crs, 1'b1)
      end
    join
  endtask : t_dup

  // Self-test through loopback for both sequence lengths
  task automatic t_bist(input logic [15:0] ctl);
    frame(0, 5'h19, ctl);
    mii_wait(400);
    frame(1, 5'h19, 16'h0);
    `CHK(v[9], 1'b1)
    frame(1, 5'h1b, 16'h0);
    `CHK(v[15:8], 8'h00)
  endtask : t_bist

  // Self-test against a stuck receive line: fail latches, count saturates
  task automatic t_bist_err;
    media_rxd   = 4'h0;
    media_rx_dv = 1'b1;
    frame(0, 5'h19, 16'h0100);
    mii_wait(400);
    frame(1, 5'h19, 16'h0);
    `CHK(v[9], 1'b0)
    frame(1, 5'h1b, 16'h0);
    `CHK(v[15:8], 8'hff)
    media_rx_dv = 1'b0;
  endtask : t_bist_err

  // Continuous self-test: looped transmit never pauses
  task automatic t_cont;
    int n;
    frame(0, 5'h1b, 16'h0020);
    frame(1, 5'h1b, 16'h0);
    `CHK(v, 16'h0020)
    n = 0;
    repeat (300) begin
      @(negedge tx_clk);
      if (mii_rx.rx_dv !== 1'b1) n++;
    end
    `CHK(n, 0)
  endtask : t_cont

  // 10 Mb half duplex: delayed and immediate collision, heartbeat length
  task automatic t_ten;
    int n;
    frame(0, 5'h00, 16'h0000);
    frame(0, 5'h19, 16'h1000);
    mii_wait(12);
    fork
      mac.send(4'h1, 8);
      begin
        repeat (2) @(negedge tx_clk);
        squelch_ok = 1'b1;
        repeat (2) @(negedge tx_clk);
        `CHK(mii_rx.col, 1'b0)
        @(negedge tx_clk);
        `CHK(mii_rx.col, 1'b1)
      end
    join
    squelch_ok = 1'b0;
    n = 0;
    repeat (10) begin
      @(negedge tx_clk);
      if (mii_rx.col === 1'b1) n++;
    end
    `CHK(n, 3)
    squelch_ok = 1'b1;
    repeat (3) @(negedge tx_clk);
    fork
      mac.send(4'h1, 4);
      begin
        repeat (2) @(negedge tx_clk);
        `CHK(mii_rx.col, 1'b1)
      end
    join
    squelch_ok = 1'b0;
  endtask : t_ten

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset spans several link clocks for the slow domain
  initial begin
    repeat (200) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1);
    t_regs();
    t_loop();
    signal_detect = 1'b1;
    media_rx_dv   = 1'b1;
    line_bit      = 1'b0;
    mii_wait(2);
    line_bit = 1'b1;
    mii_wait(2);
    line_bit = 1'b0;
    mii_wait(2);
    t_dup(16'h2100, 1'b0);
    t_dup(16'h2000, 1'b1);
    media_rx_dv = 1'b0;
    mii_wait(4);
    `CHK(mii_rx.crs, 1'b0)
    signal_detect = 1'b0;
    t_bist_err();
    frame(0, 5'h00, 16'h6000);
    t_bist(16'h0100);
    t_bist(16'h0900);
    t_cont();
    t_ten();
    end_sim();
  end

  // Watchdog well past the expected run length
  initial begin
    #380us;
    n_fail++;
    end_sim();
  end
endmodule : testbench
